/* File: ifd_clk_calc.sv */
// Clock count computation for control, string and escape opcodes
module ifd_clk_calc
  import ifd_pkg::*;
(
  input wire logic [7:0] opcode,
  input wire logic [7:0] string_op,
  input wire logic rep,
  input wire logic taken,
  input wire logic overflow,
  input wire logic [15:0] count,
  input wire logic [7:0] level,
  input wire logic word_width,
  input wire logic [1:0] mem_xfers,
  output logic [15:0] clocks,
  output logic branch,
  output logic [15:0] count_nxt,
  output logic known
);
  import ifd_pkg::*;

  logic [15:0] base_clks;
  logic [15:0] lvl16;
  logic [15:0] cnt_dec;

  assign lvl16 = {8'h00, level};
  assign cnt_dec = count - 16'h0001;

  // Per-opcode base count and branch decision
  always_comb begin
    base_clks = IFD_ZERO16;
    branch = 1'b0;
    count_nxt = count;
    known = 1'b1;
    if (rep && string_op[7:1] == IFD_OP_STRCOPY) begin
      base_clks = IFD_REP_BASE + IFD_REP_STEP * count;
      count_nxt = IFD_ZERO16;
    end else if (rep && (string_op[7:1] == IFD_OP_INS ||
                         string_op[7:1] == IFD_OP_OUTS)) begin
      base_clks = IFD_REP_BASE + IFD_REP_STEP * count;
      count_nxt = IFD_ZERO16;
    end else if (opcode[7:4] == IFD_OP_JCC_HI) begin
      branch = taken;
      base_clks = taken ? IFD_JCC_T : IFD_JCC_NT;
    end else if (opcode == IFD_OP_JUMP_IF_COUNT_ZERO) begin
      branch = (count == IFD_ZERO16);
      base_clks = branch ? IFD_JUMP_IF_COUNT_ZERO_T : IFD_JUMP_IF_COUNT_ZERO_NT;
    end else if (opcode == IFD_OP_LOOP) begin
      count_nxt = cnt_dec;
      branch = (cnt_dec != IFD_ZERO16);
      base_clks = branch ? IFD_LOOP_T : IFD_LOOP_NT;
    end else if (opcode == IFD_OP_ENTER) begin
      if (lvl16 == IFD_ZERO16)
        base_clks = IFD_ENTER_L0;
      else if (lvl16 == 16'h0001)
        base_clks = IFD_ENTER_L1;
      else
        base_clks = IFD_ENTER_BASE + IFD_ENTER_STEP * (lvl16 - 16'h0001);
    end else if (opcode == IFD_OP_INTO) begin
      branch = overflow;
      base_clks = overflow ? IFD_INTO_T : IFD_INTO_NT;
    end else if (opcode[7:3] == IFD_OP_ESC_HI) begin
      base_clks = IFD_ESC_CLKS;
    end else if (opcode[7:1] == IFD_OP_STRCOPY) begin
      base_clks = IFD_STRCOPY_ONE;
    end else begin
      known = 1'b0;
    end
  end

  // Word operations pay extra per memory transfer
  always_comb begin
    if (word_width)
      clocks = base_clks + IFD_WORD_ADD * {14'h0000, mem_xfers};
    else
      clocks = base_clks;
  end
endmodule

/* File: ifd_ea_calc.sv */
// Effective address, displacement and segment formation for a mod/rm byte
module ifd_ea_calc
  import ifd_pkg::*;
(
  input wire ifd_pkg::ifd_instr_s instr,
  input wire ifd_pkg::ifd_regs_s regs,
  input wire logic word_width,
  input wire logic ovr_en,
  input wire logic [1:0] ovr_seg,
  input wire logic str_dest,
  output ifd_pkg::ifd_ea_s ea
);
  import ifd_pkg::*;

  logic [1:0] kind;
  logic [2:0] sel;
  logic direct;
  logic uses_bp;
  logic [15:0] base;
  logic [15:0] index;

  // Field split and direct address case
  assign kind = instr.modrm[7:6];
  assign sel = instr.modrm[2:0];
  assign direct = (kind == IFD_MOD_NODISP) && (sel == IFD_RM_DIRECT);

  // Base and index choice
  always_comb begin
    base = IFD_ZERO16;
    index = IFD_ZERO16;
    unique case (sel)
      3'h0: begin base = regs.base_word_register; index = regs.source_index; end
      3'h1: begin base = regs.base_word_register; index = regs.destination_index; end
      3'h2: begin base = regs.frame_base_pointer; index = regs.source_index; end
      3'h3: begin base = regs.frame_base_pointer; index = regs.destination_index; end
      3'h4: base = regs.source_index;
      3'h5: base = regs.destination_index;
      3'h6: base = regs.frame_base_pointer;
      3'h7: base = regs.base_word_register;
    endcase
  end
  assign uses_bp = !direct && (sel == 3'h2 || sel == 3'h3 || sel == 3'h6);

  // Displacement by addressing kind, bytes right after second byte
  always_comb begin
    ea.disp = IFD_ZERO16;
    ea.disp_bytes = 2'h0;
    unique case (kind)
      IFD_MOD_NODISP: begin
        ea.disp = IFD_ZERO16;
        ea.disp_bytes = direct ? 2'h2 : 2'h0;
      end
      IFD_MOD_DISP8: begin
        ea.disp = {{8{instr.disp_lo[7]}}, instr.disp_lo};
        ea.disp_bytes = 2'h1;
      end
      IFD_MOD_DISP16: begin
        ea.disp = {instr.disp_hi, instr.disp_lo};
        ea.disp_bytes = 2'h2;
      end
      IFD_MOD_REG: begin
        ea.disp = IFD_ZERO16;
        ea.disp_bytes = 2'h0;
      end
    endcase
  end

  // Address sum; register mode reports a register code instead
  always_comb begin
    ea.is_reg = (kind == IFD_MOD_REG);
    ea.reg_code = {word_width, sel};
    if (direct)
      ea.effective_address = {instr.disp_hi, instr.disp_lo};
    else if (kind == IFD_MOD_REG)
      ea.effective_address = IFD_ZERO16;
    else
      ea.effective_address = base + index + ea.disp;
  end

  // Segment choice: string destination, override, stack default, data
  always_comb begin
    if (str_dest)
      ea.segment = IFD_SEG_EXTRA;
    else if (ovr_en)
      ea.segment = ovr_seg;
    else if (uses_bp)
      ea.segment = IFD_SEG_STACK;
    else
      ea.segment = IFD_SEG_DATA;
  end

  // Coprocessor escape opcode forwarding
  assign ea.is_escape = (instr.opcode[7:3] == IFD_OP_ESC_HI);
  assign ea.escape_op = {instr.opcode[2:0], instr.modrm[5:3]};
endmodule

/* File: ifd_pkg.sv */
// Package for the instruction format decoder: constants, types, register map
//
// Function
// - Addressing kind 11 makes operand select a register selector.
// - Addressing kind 00 gives zero displacement, no displacement bytes.
// - Addressing kind 01 takes one byte, sign-extended to 16 bits.
// - Addressing kind 10 takes two bytes, low first, as 16 bits.
// - Selects 000-011: base (BX or BP) plus index (SI or DI) plus disp.
// - Selects 100-111: SI, DI, BP or BX plus displacement.
// - Kind 00 with select 110 uses a 16-bit direct address.
// - Displacement follows the second byte; immediate data follows it.
// - Effective address formation always costs 4 clocks, already counted.
// - Segment override selector: 00 extra, 01 code, 10 stack, 11 data.
// - Register selector picks word registers if width 1, bytes if 0.
// - Memory operands formed with BP default to the stack segment.
// - String destinations via DI always use extra segment, no override; code forces it only when copy or store is the first byte.
// - Word operations add 4 clocks per memory transfer.
// - Conditional jumps take 4 clocks not taken, 13 taken.
// - Jump if count zero takes 5 clocks not taken, 15 taken.
// - Loop decrements count, branches if nonzero; 6 or 16 clocks.
// - Procedure entry: 15 at level 0, 25 at 1, 22+16(n-1) above.
// - Repeat prefix repeats string primitive by count; copy 8+8n.
// - Overflow interrupt only if overflow set: 48 taken, 4 otherwise.
// - Opcodes 11011TTT are coprocessor escapes costing 6 clocks.
package ifd_pkg;

  // AXI4-Lite register byte offsets
  localparam logic [7:0] IFD_CTRL_OFS = 8'h00;
  localparam logic [7:0] IFD_INSTR_OFS = 8'h04;
  localparam logic [7:0] IFD_BASE_OFS = 8'h08;
  localparam logic [7:0] IFD_INDEX_OFS = 8'h0C;
  localparam logic [7:0] IFD_AUX_OFS = 8'h10;
  localparam logic [7:0] IFD_EA_OFS = 8'h14;
  localparam logic [7:0] IFD_INFO_OFS = 8'h18;
  localparam logic [7:0] IFD_CLK_OFS = 8'h1C;
  localparam logic [7:0] IFD_STAT_OFS = 8'h20;

  // Control register fields
  localparam int IFD_CTRL_GO_BIT = 0;
  localparam int IFD_CTRL_OVF_BIT = 1;
  localparam int IFD_CTRL_TAKEN_BIT = 2;
  localparam int IFD_CTRL_OVR_EN_BIT = 3;
  localparam int IFD_CTRL_OVR_LSB = 4;
  localparam int IFD_CTRL_REP_BIT = 6;
  localparam int IFD_CTRL_LEVEL_LSB = 8;

  // Reset values
  localparam logic [31:0] IFD_ZERO32 = 32'h0000_0000;
  localparam logic [15:0] IFD_ZERO16 = 16'h0000;

  // Addressing kinds
  localparam logic [1:0] IFD_MOD_NODISP = 2'h0;
  localparam logic [1:0] IFD_MOD_DISP8 = 2'h1;
  localparam logic [1:0] IFD_MOD_DISP16 = 2'h2;
  localparam logic [1:0] IFD_MOD_REG = 2'h3;
  localparam logic [2:0] IFD_RM_DIRECT = 3'h6;

  // Segment selectors
  localparam logic [1:0] IFD_SEG_EXTRA = 2'h0;
  localparam logic [1:0] IFD_SEG_CODE = 2'h1;
  localparam logic [1:0] IFD_SEG_STACK = 2'h2;
  localparam logic [1:0] IFD_SEG_DATA = 2'h3;

  // Opcodes and opcode patterns
  localparam logic [7:0] IFD_OP_JZ = 8'h74;
  localparam logic [3:0] IFD_OP_JCC_HI = 4'h7;
  localparam logic [7:0] IFD_OP_JUMP_IF_COUNT_ZERO = 8'hE3;
  localparam logic [7:0] IFD_OP_LOOP = 8'hE2;
  localparam logic [7:0] IFD_OP_ENTER = 8'hC8;
  localparam logic [7:0] IFD_OP_REP = 8'hF2;
  localparam logic [7:0] IFD_OP_INTO = 8'hCE;
  localparam logic [4:0] IFD_OP_ESC_HI = 5'h1B;
  localparam logic [6:0] IFD_OP_STRCOPY = 7'h52;
  localparam logic [6:0] IFD_OP_INS = 7'h36;
  localparam logic [6:0] IFD_OP_OUTS = 7'h37;
  localparam logic [6:0] IFD_OP_STOS = 7'h55;

  // Clock counts
  localparam logic [15:0] IFD_EA_CLKS = 16'h0004;
  localparam logic [15:0] IFD_WORD_ADD = 16'h0004;
  localparam logic [15:0] IFD_JCC_NT = 16'h0004;
  localparam logic [15:0] IFD_JCC_T = 16'h000D;
  localparam logic [15:0] IFD_JUMP_IF_COUNT_ZERO_NT = 16'h0005;
  localparam logic [15:0] IFD_JUMP_IF_COUNT_ZERO_T = 16'h000F;
  localparam logic [15:0] IFD_LOOP_NT = 16'h0006;
  localparam logic [15:0] IFD_LOOP_T = 16'h0010;
  localparam logic [15:0] IFD_ENTER_L0 = 16'h000F;
  localparam logic [15:0] IFD_ENTER_L1 = 16'h0019;
  localparam logic [15:0] IFD_ENTER_BASE = 16'h0016;
  localparam logic [15:0] IFD_ENTER_STEP = 16'h0010;
  localparam logic [15:0] IFD_REP_BASE = 16'h0008;
  localparam logic [15:0] IFD_REP_STEP = 16'h0008;
  localparam logic [15:0] IFD_STRCOPY_ONE = 16'h000E;
  localparam logic [15:0] IFD_INTO_T = 16'h0030;
  localparam logic [15:0] IFD_INTO_NT = 16'h0004;
  localparam logic [15:0] IFD_ESC_CLKS = 16'h0006;

  // Decode request and result
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [7:0] disp_lo;
    logic [7:0] disp_hi;
  } ifd_instr_s;

  typedef struct packed {
    logic [15:0] base_word_register;
    logic [15:0] frame_base_pointer;
    logic [15:0] source_index;
    logic [15:0] destination_index;
    logic [15:0] count_register;
  } ifd_regs_s;

  typedef struct packed {
    logic [15:0] effective_address;
    logic [15:0] disp;
    logic [1:0] disp_bytes;
    logic is_reg;
    logic [3:0] reg_code;
    logic [1:0] segment;
    logic [5:0] escape_op;
    logic is_escape;
  } ifd_ea_s;

endpackage

/* File: ifd_queue_model.sv */
// Prefetch queue model: instruction bytes per slot, in queue order
module ifd_queue_model
  import ifd_pkg::*;
(
  input wire logic [3:0] slot,
  output ifd_pkg::ifd_instr_s word
);
  // Opcode, mod/rm, displacement low then high
  always_comb begin
    case (slot)
      4'h0: word = '{8'h20, 8'h80, 8'h34, 8'h12};
      4'h1: word = '{8'h20, 8'h46, 8'h80, 8'h00};
      4'h2: word = '{8'h20, 8'h06, 8'h78, 8'h56};
      4'h3: word = '{8'h20, 8'h03, 8'h99, 8'h99};
      4'h4: word = '{8'h20, 8'h47, 8'h7F, 8'h00};
      4'h5: word = '{8'h20, 8'h45, 8'h10, 8'h00};
      default: word = '{8'h90, 8'hA5, 8'h5A, 8'hA5};
    endcase
  end
endmodule

/* File: ifd_top.sv */
// Instruction format decoder top: AXI4-Lite registers and decode pipeline
module ifd_top
  import ifd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import ifd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [31:0] ctrl_r;
  logic [31:0] instr_r;
  logic [31:0] base_r;
  logic [31:0] index_r;
  logic [31:0] aux_r;
  logic [31:0] ea_res_r;
  logic [31:0] info_r;
  logic [31:0] clk_res_r;
  logic done_r;
  logic busy_r;
  logic [1:0] wait_r;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel handshake

  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic go;

  assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  assign do_write = (aw_held_r || (s_axi_awvalid && s_axi_awready)) &&
                    (w_held_r || (s_axi_wvalid && s_axi_wready)) &&
                    !s_axi_bvalid;

  // Address and data captured in either order
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= IFD_ZERO32;
      w_strb_r <= 4'h0;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  // Ready flags and write response
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !s_axi_bvalid && !do_write && !aw_held_r &&
                       !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !s_axi_bvalid && !do_write && !w_held_r &&
                      !(s_axi_wvalid && s_axi_wready);
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Unused combos handled: hit only for writable offsets
  assign wr_hit = (wr_addr == IFD_CTRL_OFS) || (wr_addr == IFD_INSTR_OFS) ||
                  (wr_addr == IFD_BASE_OFS) || (wr_addr == IFD_INDEX_OFS) ||
                  (wr_addr == IFD_AUX_OFS);
  assign go = do_write && wr_addr == IFD_CTRL_OFS && wr_strb[0] &&
              wr_data[IFD_CTRL_GO_BIT];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Software-written registers

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= IFD_ZERO32;
      instr_r <= IFD_ZERO32;
      base_r <= IFD_ZERO32;
      index_r <= IFD_ZERO32;
      aux_r <= IFD_ZERO32;
    end else if (do_write) begin
      unique case (wr_addr)
        IFD_CTRL_OFS: ctrl_r <= merge(ctrl_r, wr_data, wr_strb) &
                                32'hFFFF_FFFE;
        IFD_INSTR_OFS: instr_r <= merge(instr_r, wr_data, wr_strb);
        IFD_BASE_OFS: base_r <= merge(base_r, wr_data, wr_strb);
        IFD_INDEX_OFS: index_r <= merge(index_r, wr_data, wr_strb);
        IFD_AUX_OFS: aux_r <= merge(aux_r, wr_data, wr_strb);
        default: ;
      endcase
    end else if (busy_r && wait_r == 2'h0) begin
      aux_r[15:0] <= count_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode datapath

  ifd_instr_s instr;
  ifd_regs_s regs;
  ifd_ea_s ea;
  logic rep_pfx;
  logic str_dest;
  logic mem_op;
  logic [1:0] xfers;
  logic [15:0] clocks;
  logic branch;
  logic [15:0] count_nxt;
  logic known;
  logic [7:0] op;

  // Repeat prefix moves the primitive into the second byte
  assign rep_pfx = ctrl_r[IFD_CTRL_REP_BIT] ||
                   instr_r[7:0] == IFD_OP_REP;
  assign op = instr_r[7:0];
  assign instr.opcode = instr_r[7:0];
  assign instr.modrm = instr_r[15:8];
  assign instr.disp_lo = instr_r[23:16];
  assign instr.disp_hi = instr_r[31:24];
  assign regs.base_word_register = base_r[15:0];
  assign regs.frame_base_pointer = base_r[31:16];
  assign regs.source_index = index_r[15:0];
  assign regs.destination_index = index_r[31:16];
  assign regs.count_register = aux_r[15:0];
  assign str_dest = (op[7:1] == IFD_OP_STRCOPY) || (op[7:1] == IFD_OP_STOS);
  // Control transfers carry no operand byte, so no memory word moves
  assign mem_op = (instr_r[15:14] != IFD_MOD_REG) &&
                  (op[7:4] != IFD_OP_JCC_HI) && (op != IFD_OP_JUMP_IF_COUNT_ZERO) &&
                  (op != IFD_OP_LOOP) && (op != IFD_OP_ENTER) &&
                  (op != IFD_OP_INTO);
  assign xfers = (op[7:1] == IFD_OP_STRCOPY) ? 2'h2 :
                 (rep_pfx ? 2'h0 : {1'b0, mem_op && op[7:3] != IFD_OP_ESC_HI});

  ifd_ea_calc u_ea (
    .instr(instr),
    .regs(regs),
    .word_width(op[0]),
    .ovr_en(ctrl_r[IFD_CTRL_OVR_EN_BIT]),
    .ovr_seg(ctrl_r[IFD_CTRL_OVR_LSB +: 2]),
    .str_dest(str_dest),
    .ea(ea)
  );

  ifd_clk_calc u_clk (
    .opcode(op),
    .string_op(instr_r[15:8]),
    .rep(rep_pfx),
    .taken(ctrl_r[IFD_CTRL_TAKEN_BIT]),
    .overflow(ctrl_r[IFD_CTRL_OVF_BIT]),
    .count(aux_r[15:0]),
    .level(ctrl_r[IFD_CTRL_LEVEL_LSB +: 8]),
    .word_width(rep_pfx ? instr_r[8] : op[0]),
    .mem_xfers(xfers),
    .clocks(clocks),
    .branch(branch),
    .count_nxt(count_nxt),
    .known(known)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode sequencing: address formation wait then result capture

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      wait_r <= 2'h0;
      done_r <= 1'b0;
      ea_res_r <= IFD_ZERO32;
      info_r <= IFD_ZERO32;
      clk_res_r <= IFD_ZERO32;
    end else if (go) begin
      busy_r <= 1'b1;
      wait_r <= 2'(IFD_EA_CLKS - 16'h0001);
      done_r <= 1'b0;
    end else if (busy_r) begin
      if (wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end else begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
        ea_res_r <= {ea.disp, ea.effective_address};
        info_r <= {14'h0000, known, branch, ea.is_escape, ea.escape_op,
                   ea.segment, ea.reg_code, ea.is_reg, ea.disp_bytes};
        clk_res_r <= {16'h0000, clocks};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  logic [31:0] rd_mux;
  logic rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      IFD_CTRL_OFS: rd_mux = ctrl_r;
      IFD_INSTR_OFS: rd_mux = instr_r;
      IFD_BASE_OFS: rd_mux = base_r;
      IFD_INDEX_OFS: rd_mux = index_r;
      IFD_AUX_OFS: rd_mux = aux_r;
      IFD_EA_OFS: rd_mux = ea_res_r;
      IFD_INFO_OFS: rd_mux = info_r;
      IFD_CLK_OFS: rd_mux = clk_res_r;
      IFD_STAT_OFS: rd_mux = {30'h0000_0000, busy_r, done_r};
      default: begin
        rd_mux = IFD_ZERO32;
        rd_hit = 1'b0;
      end
    endcase
  end

  // One read at a time, answered the cycle after acceptance
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= IFD_ZERO32;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* File: ifd_top_assertions.sv */
// Checker on the decoder top's register bus ports
module ifd_top_assertions
  import ifd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] rd_addr_r;
  wire info_rd = s_axi_rvalid && (rd_addr_r == IFD_INFO_OFS);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Address of the read being answered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) rd_addr_r <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_addr_r <= s_axi_araddr;
  end

  // Bus answers and holding
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read moved");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("late write answer");
  a_read_answer: assert property ($rose(s_axi_arvalid && s_axi_arready)
    |=> s_axi_rvalid) else $error("late read answer");
  a_write_refused: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid ##1 !s_axi_bvalid) else $error("bvalid repeated");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
    |-> s_axi_rdata == 32'h0 && !s_axi_arready) else $error("error data");
  // Decode result fields
  a_reg_nodisp: assert property (
    info_rd && s_axi_rdata[2] |-> s_axi_rdata[1:0] == 2'h0)
    else $error("register mode with displacement");
  a_disp_count: assert property (
    info_rd |-> s_axi_rdata[1:0] != 2'h3) else $error("bad byte count");
  a_esc_flags: assert property (
    info_rd && s_axi_rdata[15] |-> s_axi_rdata[17:16] == 2'h2)
    else $error("escape flags");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_esc: cover property (info_rd && s_axi_rdata[15]);
endmodule
//////////////////////////////////////////////////////////////
bind ifd_top ifd_top_assertions u_chk (.*);

/* File: testbench.sv */
// Testbench for the instruction format decoder
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import ifd_pkg::*;
  logic sys_clk, rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [3:0] slot;
  ifd_instr_s qword;
  logic [31:0] ea, inf, ck, aux, v;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;

  ifd_top dut (.*);
  ifd_queue_model u_q (.slot(slot), .word(qword));

  // Clock, 4 ns
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Hang ceiling
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task print_verdict();
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // Bus write: both channels offered, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One decode, waits for done, fetches results
  task dec(input logic [31:0] c, i, x);
    int k;
    wr(IFD_INSTR_OFS, i);
    wr(IFD_AUX_OFS, x);
    wr(IFD_CTRL_OFS, c | 32'h1);
    rd(IFD_STAT_OFS, v);
    chk("forming", {30'h0, v[1:0]}, 32'h2);
    k = 0;
    while (v[1:0] !== 2'h1 && k < 50) begin
      rd(IFD_STAT_OFS, v);
      k++;
    end
    chk("done", {30'h0, v[1:0]}, 32'h1);
    rd(IFD_EA_OFS, ea);
    rd(IFD_INFO_OFS, inf);
    rd(IFD_CLK_OFS, ck);
    rd(IFD_AUX_OFS, aux);
  endtask

  task ckc(input logic [31:0] c, i, x, e);
    dec(c, i, x);
    chk("clocks", {16'h0, ck[15:0]}, e);
  endtask

  task ea_case(input logic [3:0] s, input logic [31:0] c, e,
               input logic d, input logic [3:0] f);
    slot = s;
    #1;
    dec(c, {qword.disp_hi, qword.disp_lo, qword.modrm, qword.opcode}, 32'h0);
    chk("ea", d ? ea : {16'h0, ea[15:0]}, e);
    chk("seg bytes", {28'h0, inf[8:7], inf[1:0]}, {28'h0, f});
  endtask

  task t_ea();
    ea_case(4'h0, 32'h0, 32'h1234_2254, 1'b1, 4'hE);
    ea_case(4'h1, 32'h0, 32'hFF80_0080, 1'b1, 4'h9);
    ea_case(4'h2, 32'h8, 32'h0000_5678, 1'b0, 4'h2);
    ea_case(4'h3, 32'h0, 32'h0000_0103, 1'b1, 4'h8);
    ea_case(4'h4, 32'h0, 32'h007F_107F, 1'b1, 4'hD);
    ea_case(4'h5, 32'h18, 32'h0010_0013, 1'b1, 4'h5);
  endtask

  task t_reg();
    dec(32'h0, 32'hED21, 32'h0);
    chk("reg word", {27'h0, inf[6:2]}, 32'h1B);
    dec(32'h0, 32'hE420, 32'h0);
    chk("reg byte", {27'h0, inf[6:2]}, 32'h09);
  endtask

  task t_branch();
    ckc(32'h0, 32'h74, 32'h0, 32'h4);
    ckc(32'h4, 32'h74, 32'h0, 32'hD);
    ckc(32'h4, 32'hE3, 32'h0, 32'hF);
    ckc(32'h0, 32'hE3, 32'h5, 32'h5);
    chk("branch", {31'h0, inf[16]}, 32'h0);
    ckc(32'h4, 32'hE2, 32'h2, 32'h10);
    chk("branch", {31'h0, inf[16]}, 32'h1);
    chk("count", aux, 32'h1);
    ckc(32'h0, 32'hE2, 32'h1, 32'h6);
  endtask

  task t_enter();
    ckc(32'h0, 32'hC8, 32'h0, 32'hF);
    ckc(32'h100, 32'hC8, 32'h0, 32'h19);
    ckc(32'h200, 32'hC8, 32'h0, 32'h26);
    ckc(32'h300, 32'hC8, 32'h0, 32'h36);
  endtask

  task t_string();
    ckc(32'h0, 32'hA4, 32'h0, 32'hE);
    ckc(32'h38, 32'hA5, 32'h0, 32'h16);
    chk("dest seg", {30'h0, inf[8:7]}, 32'h0);
    ckc(32'h0, 32'hA4F2, 32'h3, 32'h20);
    chk("count", aux, 32'h0);
    ckc(32'h0, 32'hA4F2, 32'h0, 32'h8);
  endtask

  task t_other();
    ckc(32'h2, 32'hCE, 32'h0, 32'h30);
    ckc(32'h0, 32'hCE, 32'h0, 32'h4);
    ckc(32'h0, 32'hE8D9, 32'h0, 32'h6);
    chk("esc", {25'h0, inf[15:9]}, 32'h4D);
  endtask

  // Reset, bus checks, then the scenarios
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = '0;
    s_axi_wdata = 32'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    slot = 4'h0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(IFD_CTRL_OFS, v);
    chk("ctrl reset", v, IFD_ZERO32);
    rd(8'h40, v);
    chk("rresp", {30'h0, rsp}, 32'h2);
    wr(8'h40, 32'hFFFF_FFFF);
    chk("bresp", {30'h0, rsp}, 32'h2);
    wr(IFD_BASE_OFS, 32'h0100_1000);
    wr(IFD_INDEX_OFS, 32'h0003_0020);
    rd(IFD_BASE_OFS, v);
    chk("base", v, 32'h0100_1000);
    t_ea();
    t_reg();
    t_branch();
    t_enter();
    t_string();
    t_other();
    print_verdict();
  end
endmodule
